/* common/ipw_pkg.sv */
// Constants shared by the image port write sequencer: register indices,
// field positions, reset values and timing figures.
// Assumes a single 50 MHz clock and a 32-bit classic Wishbone register bus.
//
// Notes on behaviour
// - Non-interlaced frame start loads image start address.
// - Interlaced odd field loads start plus row.
// - Mask zero advances address, writes nothing.
// - Full line count drops ready until sync.
// - Early line sync clears count, drops remainder.
// - Line sync edge adds row except on the first line after frame start, raises ready.
// - Interlaced line step is two rows.
// - Address generator configured by registers E0-E6.
// - Line length comes from registers F3-F4.
// - Port sustains up to 25 MB/s: one request edge per two 50 MHz clocks.
// - Bytes go to memory with address tracking.
`default_nettype none
package ipw_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 22;
	localparam int CNT_W  = 16;

	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_START_LO  = 8'he0;
	localparam logic [7:0] IDX_START_MID = 8'he1;
	localparam logic [7:0] IDX_START_HI  = 8'he2;
	localparam logic [7:0] IDX_RSVD_E3   = 8'he3;
	localparam logic [7:0] IDX_ROW_LO    = 8'he4;
	localparam logic [7:0] IDX_ROW_HI    = 8'he5;
	localparam logic [7:0] IDX_RSVD_E6   = 8'he6;
	localparam logic [7:0] IDX_STATUS    = 8'hf0;
	localparam logic [7:0] IDX_CNT_LO    = 8'hf1;
	localparam logic [7:0] IDX_CNT_HI    = 8'hf2;
	localparam logic [7:0] IDX_LEN_LO    = 8'hf3;
	localparam logic [7:0] IDX_LEN_HI    = 8'hf4;
	localparam logic [7:0] IDX_CTRL      = 8'hf7;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTRL_EN_BIT      = 0;
	localparam int CTRL_ILACE_BIT   = 1;
	localparam int STAT_READY_BIT   = 0;
	localparam int STAT_WAIT_BIT    = 1;
	localparam int STAT_FRAMED_BIT  = 2;
	localparam int START_HI_BITS    = ADDR_W - 16;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] START_RST = 22'h000000;
	localparam logic [CNT_W-1:0]  ROW_RST   = 16'h0000;
	localparam logic [CNT_W-1:0]  LEN_RST   = 16'h0000;
	localparam logic [7:0]        CTRL_RST  = 8'h00;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int BYTE_TIME_NS  = 25;   // One byte at 40 MB/s
	localparam int BYTE_CYC      = (BYTE_TIME_NS / CLK_PERIOD_NS) < 1 ? 1
	                               : (BYTE_TIME_NS / CLK_PERIOD_NS);
	localparam int SYNC_STAGES   = 2;

endpackage
`default_nettype wire

/* common/ipw_cfg_if.sv */
// Carrier between the register slave and the sequencer core.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface ipw_cfg_if;
	logic [ipw_pkg::ADDR_W-1:0] start_addr;
	logic [ipw_pkg::CNT_W-1:0]  row_offset;
	logic [ipw_pkg::CNT_W-1:0]  xfer_len;
	logic                       interlace;
	logic                       port_en;
	logic                       ready;
	logic                       waiting;
	logic                       framed;
	logic [ipw_pkg::CNT_W-1:0]  dword_cnt;

	modport regs (output start_addr, row_offset, xfer_len, interlace, port_en,
	              input ready, waiting, framed, dword_cnt);
	modport core (input start_addr, row_offset, xfer_len, interlace, port_en,
	              output ready, waiting, framed, dword_cnt);
endinterface
`default_nettype wire

/* rtl/ipw_sync.sv */
// Two-flop synchroniser with an edge stage for a bundle of port inputs.
// Assumes inputs may change at any time relative to sys_clk.
`timescale 1ns/10ps
`default_nettype none
module ipw_sync
#(
	parameter int W = 1
)
(
	input  wire logic         sys_clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	if (W < 1)
	begin : g_bad_width
		$error("ipw_sync: W must be at least 1");
	end

	logic [W-1:0] meta;
	logic [W-1:0] stable;
	logic [W-1:0] prev;

	// Only the second stage and beyond are looked at by logic
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta   <= '0;
			stable <= '0;
			prev   <= '0;
		end
		else
		begin
			meta   <= async_in;
			stable <= meta;
			prev   <= stable;
		end
	end

	assign level = stable;
	assign rise  = stable & ~prev;
	assign fall  = ~stable & prev;
endmodule // ipw_sync
`default_nettype wire

/* rtl/ipw_regs.sv */
// Classic Wishbone register slave for the image port.
// Assumes 32-bit data; 8-bit registers in the low byte, one word each.
`timescale 1ns/10ps
`default_nettype none
module ipw_regs
(
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	ipw_cfg_if.regs          cfg
);
	logic [ipw_pkg::ADDR_W-1:0] start;
	logic [ipw_pkg::CNT_W-1:0]  row;
	logic [ipw_pkg::CNT_W-1:0]  len;
	logic [7:0]                 ctrl;
	logic                       ack;
	logic [31:0]                rdat;
	logic [ipw_pkg::ADDR_W-1:0] next_start;
	logic [ipw_pkg::CNT_W-1:0]  next_row;
	logic [ipw_pkg::CNT_W-1:0]  next_len;
	logic [7:0]                 next_ctrl;
	logic                       next_ack;
	logic [31:0]                next_rdat;
	logic                       take;
	logic [7:0]                 idx;
	logic [7:0]                 rbyte;

	assign take = wb_cyc_i && wb_stb_i && !ack;
	assign idx  = wb_adr_i[9:2];

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	always_comb
	begin
		next_start = start;
		next_row   = row;
		next_len   = len;
		next_ctrl  = ctrl;
		next_ack   = take;
		next_rdat  = rdat;
		rbyte      = 8'h00;
		case (idx)
			ipw_pkg::IDX_START_LO:  rbyte = start[7:0];
			ipw_pkg::IDX_START_MID: rbyte = start[15:8];
			ipw_pkg::IDX_START_HI:  rbyte = {2'h0, start[ipw_pkg::ADDR_W-1:16]};
			ipw_pkg::IDX_ROW_LO:    rbyte = row[7:0];
			ipw_pkg::IDX_ROW_HI:    rbyte = row[15:8];
			ipw_pkg::IDX_LEN_LO:    rbyte = len[7:0];
			ipw_pkg::IDX_LEN_HI:    rbyte = len[15:8];
			ipw_pkg::IDX_CTRL:      rbyte = ctrl;
			ipw_pkg::IDX_STATUS:    rbyte = {5'h00, cfg.framed, cfg.waiting, cfg.ready};
			ipw_pkg::IDX_CNT_LO:    rbyte = cfg.dword_cnt[7:0];
			ipw_pkg::IDX_CNT_HI:    rbyte = cfg.dword_cnt[15:8];
			default:                rbyte = 8'h00;
		endcase
		if (take && !wb_we_i)
			next_rdat = {24'h000000, rbyte};
		if (take && wb_we_i && wb_sel_i[0])
		begin
			case (idx)
				ipw_pkg::IDX_START_LO:  next_start[7:0]  = wb_dat_i[7:0];
				ipw_pkg::IDX_START_MID: next_start[15:8] = wb_dat_i[7:0];
				ipw_pkg::IDX_START_HI:
					next_start[ipw_pkg::ADDR_W-1:16] = wb_dat_i[ipw_pkg::START_HI_BITS-1:0];
				ipw_pkg::IDX_ROW_LO:    next_row[7:0]    = wb_dat_i[7:0];
				ipw_pkg::IDX_ROW_HI:    next_row[15:8]   = wb_dat_i[7:0];
				ipw_pkg::IDX_LEN_LO:    next_len[7:0]    = wb_dat_i[7:0];
				ipw_pkg::IDX_LEN_HI:    next_len[15:8]   = wb_dat_i[7:0];
				ipw_pkg::IDX_CTRL:      next_ctrl        = wb_dat_i[7:0];
				default:                next_ctrl        = ctrl;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			start <= ipw_pkg::START_RST;
			row   <= ipw_pkg::ROW_RST;
			len   <= ipw_pkg::LEN_RST;
			ctrl  <= ipw_pkg::CTRL_RST;
			ack   <= 1'b0;
			rdat  <= 32'h00000000;
		end
		else
		begin
			start <= next_start;
			row   <= next_row;
			len   <= next_len;
			ctrl  <= next_ctrl;
			ack   <= next_ack;
			rdat  <= next_rdat;
		end
	end

	assign wb_ack_o       = ack;
	assign wb_dat_o       = rdat;
	assign cfg.start_addr = start;
	assign cfg.row_offset = row;
	assign cfg.xfer_len   = len;
	assign cfg.interlace  = ctrl[ipw_pkg::CTRL_ILACE_BIT];
	assign cfg.port_en    = ctrl[ipw_pkg::CTRL_EN_BIT];
endmodule // ipw_regs
`default_nettype wire

/* rtl/ipw_top.sv */
// Image port write sequencer: takes bytes from an asynchronous sender,
// generates linear display memory addresses and paces the sender.
// Assumes the display memory side accepts a write strobe on every cycle.
`timescale 1ns/10ps
`default_nettype none
module ipw_top
(
	input  wire logic                       sys_clk,
	input  wire logic                       rstn,
	input  wire logic                       wb_cyc_i,
	input  wire logic                       wb_stb_i,
	input  wire logic                       wb_we_i,
	input  wire logic [9:0]                 wb_adr_i,
	input  wire logic [3:0]                 wb_sel_i,
	input  wire logic [31:0]                wb_dat_i,
	output logic      [31:0]                wb_dat_o,
	output logic                            wb_ack_o,
	input  wire logic                       frame_sync_in,
	input  wire logic                       line_sync_in,
	input  wire logic                       odd_field_in,
	input  wire logic                       write_request_n,
	input  wire logic [7:0]                 pixel_byte_in,
	input  wire logic                       byte_mask_in,
	output logic                            port_ready_out,
	output logic                            mem_we,
	output logic      [ipw_pkg::ADDR_W-1:0] mem_addr,
	output logic      [7:0]                 mem_data
);
	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	// Request phases must outlast the synchroniser to be seen at all
	if (ipw_pkg::BYTE_CYC < ipw_pkg::SYNC_STAGES - 1)
	begin : g_rate_chk
		$error("ipw_top: clock too slow for the port byte rate");
	end

	// The row step is a zero-padded concatenation of fixed parts
	if (ipw_pkg::ADDR_W != ipw_pkg::CNT_W + 6)
	begin : g_width_chk
		$error("ipw_top: address width must be row width plus six");
	end

	typedef enum logic [1:0] {
		IPW_IDLE,
		IPW_LINE_WAIT,
		IPW_ACTIVE
	} ipw_state_t;

	localparam int SW = 13;

	// Rows are doublewords, so a row step is the offset times four bytes
	function automatic logic [ipw_pkg::ADDR_W-1:0] add_rows
	(
		input logic [ipw_pkg::ADDR_W-1:0] base,
		input logic [ipw_pkg::CNT_W-1:0]  off,
		input logic                       two
	);
		logic [ipw_pkg::ADDR_W-1:0] step;
		step = {4'h0, off, 2'b00};
		if (two)
			step = {step[ipw_pkg::ADDR_W-2:0], 1'b0};
		add_rows = base + step;
	endfunction

	ipw_cfg_if cfg ();

	// ------------------------------------------------------------
	// Register slave
	// ------------------------------------------------------------
	ipw_regs u_regs
	(
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.wb_cyc_i (wb_cyc_i),
		.wb_stb_i (wb_stb_i),
		.wb_we_i  (wb_we_i),
		.wb_adr_i (wb_adr_i),
		.wb_sel_i (wb_sel_i),
		.wb_dat_i (wb_dat_i),
		.wb_dat_o (wb_dat_o),
		.wb_ack_o (wb_ack_o),
		.cfg      (cfg.regs)
	);

	// ------------------------------------------------------------
	// Input synchroniser
	// ------------------------------------------------------------
	// Data and mask ride the same delay as the request so they stay aligned
	logic [SW-1:0] s_level;
	logic [SW-1:0] s_rise;
	logic [SW-1:0] s_fall;

	ipw_sync #(.W(SW)) u_sync
	(
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.async_in ({odd_field_in, byte_mask_in, pixel_byte_in,
		            frame_sync_in, line_sync_in, write_request_n}),
		.level    (s_level),
		.rise     (s_rise),
		.fall     (s_fall)
	);

	logic       wr_edge;
	logic       ls_lead;
	logic       fs_lead;
	logic [7:0] pix;
	logic       mask;
	logic       odd;

	assign wr_edge = s_fall[0];
	assign ls_lead = s_rise[1];
	assign fs_lead = s_rise[2];
	assign pix     = s_level[10:3];
	assign mask    = s_level[11];
	assign odd     = s_level[12];

	// ------------------------------------------------------------
	// Sequencer state
	// ------------------------------------------------------------
	ipw_state_t                 state;
	logic [ipw_pkg::ADDR_W-1:0] line_base;
	logic [ipw_pkg::ADDR_W-1:0] cur_addr;
	logic [ipw_pkg::CNT_W-1:0]  dword_cnt;
	logic [1:0]                 lane;
	logic                       first_line;
	logic                       we_q;
	logic [ipw_pkg::ADDR_W-1:0] addr_q;
	logic [7:0]                 data_q;

	ipw_state_t                 next_state;
	logic [ipw_pkg::ADDR_W-1:0] next_line_base;
	logic [ipw_pkg::ADDR_W-1:0] next_cur_addr;
	logic [ipw_pkg::CNT_W-1:0]  next_dword_cnt;
	logic [1:0]                 next_lane;
	logic                       next_first_line;
	logic                       next_we;
	logic [ipw_pkg::ADDR_W-1:0] next_addr;
	logic [7:0]                 next_data;
	logic [ipw_pkg::CNT_W-1:0]  cnt_inc;
	logic [ipw_pkg::ADDR_W-1:0] line_next;
	logic                       byte_take;

	assign cnt_inc = dword_cnt + 16'h0001;

	// Disable beats frame sync, which beats line sync; a write edge that
	// meets a sync edge in one cycle is dropped with the rest of the line
	always_comb
	begin
		next_state      = state;
		next_line_base  = line_base;
		next_cur_addr   = cur_addr;
		next_dword_cnt  = dword_cnt;
		next_lane       = lane;
		next_first_line = first_line;
		byte_take       = 1'b0;
		line_next       = add_rows(line_base, cfg.row_offset, cfg.interlace);
		if (!cfg.port_en)
		begin
			next_state = IPW_IDLE;
		end
		else if (fs_lead)
		begin
			// Frame start: wait for the first line sync with ready low
			if (cfg.interlace && odd)
				next_line_base = add_rows(cfg.start_addr, cfg.row_offset, 1'b0);
			else
				next_line_base = cfg.start_addr;
			next_cur_addr   = next_line_base;
			next_dword_cnt  = '0;
			next_lane       = 2'b00;
			next_first_line = 1'b1;
			next_state      = IPW_LINE_WAIT;
		end
		else if (ls_lead && state != IPW_IDLE)
		begin
			// Early sync drops the rest of the line and clears the count
			if (first_line)
			begin
				next_cur_addr = line_base;
			end
			else
			begin
				next_line_base = line_next;
				next_cur_addr  = line_next;
			end
			next_dword_cnt  = '0;
			next_lane       = 2'b00;
			next_first_line = 1'b0;
			next_state      = IPW_ACTIVE;
		end
		else
		begin
			case (state)
				IPW_IDLE:
				begin
					next_state = IPW_IDLE;
				end
				IPW_LINE_WAIT:
				begin
					next_state = IPW_LINE_WAIT;
				end
				IPW_ACTIVE:
				begin
					// Writes during line sync high are ignored
					if (wr_edge && !s_level[1])
					begin
						byte_take     = 1'b1;
						next_cur_addr = cur_addr + 22'h000001;
						next_lane     = lane + 2'b01;
						if (lane == 2'b11)
						begin
							next_dword_cnt = cnt_inc;
							if (cnt_inc == cfg.xfer_len)
								next_state = IPW_LINE_WAIT;
						end
					end
				end
				default:
				begin
					next_state = IPW_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state      <= IPW_IDLE;
			line_base  <= ipw_pkg::START_RST;
			cur_addr   <= ipw_pkg::START_RST;
			dword_cnt  <= '0;
			lane       <= 2'b00;
			first_line <= 1'b0;
		end
		else
		begin
			state      <= next_state;
			line_base  <= next_line_base;
			cur_addr   <= next_cur_addr;
			dword_cnt  <= next_dword_cnt;
			lane       <= next_lane;
			first_line <= next_first_line;
		end
	end

	// ------------------------------------------------------------
	// Display memory write port
	// ------------------------------------------------------------
	// Masked bytes still move the pointer but never raise the strobe;
	// address and data register with the strobe so memory sees them aligned
	always_comb
	begin
		next_we   = 1'b0;
		next_addr = addr_q;
		next_data = data_q;
		if (byte_take)
		begin
			next_we   = mask;
			next_addr = cur_addr;
			next_data = pix;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			we_q   <= 1'b0;
			addr_q <= ipw_pkg::START_RST;
			data_q <= 8'h00;
		end
		else
		begin
			we_q   <= next_we;
			addr_q <= next_addr;
			data_q <= next_data;
		end
	end

	// ------------------------------------------------------------
	// Outputs and status
	// ------------------------------------------------------------
	// One byte per detected request edge, so the rate is bounded by the
	// sender's toggle rate and by one fall per two clocks: 25 MB/s at 50 MHz
	assign port_ready_out = (state == IPW_ACTIVE);
	assign mem_we         = we_q;
	assign mem_addr       = addr_q;
	assign mem_data       = data_q;

	// ------------------------------------------------------------
	// Status towards the register slave
	// ------------------------------------------------------------
	// Ready is a plain decode of the state, so it drops as the line ends;
	// framed stays up from frame sync until the port is disabled
	assign cfg.ready     = (state == IPW_ACTIVE);
	assign cfg.waiting   = (state == IPW_LINE_WAIT);
	assign cfg.framed    = (state != IPW_IDLE);
	assign cfg.dword_cnt = dword_cnt;
endmodule // ipw_top
`default_nettype wire

/* testbench/ipw_chk.sv */
// Port-level checks for the image port write sequencer.
// Assumes write phases of at least three clocks and sync pulses of six.
`timescale 1ns/10ps
`default_nettype none
module ipw_chk
(
	input wire logic        sys_clk,
	input wire logic        rstn,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        frame_sync_in,
	input wire logic        line_sync_in,
	input wire logic        write_request_n,
	input wire logic [7:0]  pixel_byte_in,
	input wire logic        byte_mask_in,
	input wire logic        port_ready_out,
	input wire logic        mem_we,
	input wire logic [7:0]  mem_data
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence s_quiet;
		!mem_we [*3];
	endsequence
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper");
	a_we_masked: assert property (mem_we |-> $past(byte_mask_in, 2)) else $error("masked write");
	a_data_match: assert property (mem_we |-> mem_data == $past(pixel_byte_in, 2))
		else $error("write data differs");
	a_ready_gate: assert property (!port_ready_out [*6] |-> !mem_we) else $error("write idle");
	a_ready_cause: assert property ($rose(port_ready_out) |-> $past(line_sync_in, 3))
		else $error("ready rose without line sync");
	a_frame_drop: assert property ($rose(frame_sync_in) |-> ##[2:5] !port_ready_out)
		else $error("ready kept over frame sync");
	a_sync_quiet: assert property ($fell(write_request_n) |-> s_quiet) else $error("too fast");
	a_byte_lands: assert property ($fell(write_request_n) && port_ready_out && byte_mask_in
		&& !line_sync_in |-> ##[2:6] mem_we) else $error("byte lost");
endmodule // ipw_chk
bind ipw_top ipw_chk u_chk (.sys_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
	.frame_sync_in, .line_sync_in, .write_request_n, .pixel_byte_in, .byte_mask_in,
	.port_ready_out, .mem_we, .mem_data);
`default_nettype wire

/* testbench/ipw_sender.sv */
// Model of the image processor that pushes bytes into the port.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/10ps
`default_nettype none
module ipw_sender
(
	input  wire logic       sys_clk,
	input  wire logic       port_ready_out,
	output logic            frame_sync_in,
	output logic            line_sync_in,
	output logic            odd_field_in,
	output logic            write_request_n,
	output logic            byte_mask_in,
	output logic      [7:0] pixel_byte_in
);
	// ------------------------------------------------------------
	// Sender actions
	// ------------------------------------------------------------
	initial
	begin
		frame_sync_in = 1'b0;
		line_sync_in = 1'b0;
		odd_field_in = 1'b0;
		write_request_n = 1'b1;
		byte_mask_in = 1'b0;
		pixel_byte_in = 8'h00;
	end
	task frame(input logic odd);
		@(posedge sys_clk);
		frame_sync_in <= 1'b1;
		odd_field_in <= odd;
		repeat (6) @(posedge sys_clk);
		frame_sync_in <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask
	task line;
		@(posedge sys_clk);
		line_sync_in <= 1'b1;
		repeat (6) @(posedge sys_clk);
		line_sync_in <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask
	// Request held high until ready is seen; data held well past the synchroniser
	task send(input logic [7:0] b, input logic m);
		@(posedge sys_clk);
		while (port_ready_out !== 1'b1) @(posedge sys_clk);
		pixel_byte_in <= b;
		byte_mask_in <= m;
		@(posedge sys_clk);
		write_request_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		write_request_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		pixel_byte_in <= ~b;
		byte_mask_in <= ~m;
	endtask
endmodule // ipw_sender
`default_nettype wire

/* testbench/image_port_write_sequencer_bench.sv */
// Self-checking bench for the image port write sequencer.
// Assumes ipw_chk is bound to ipw_top and ipw_sender drives the port.
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp_v, act_v) begin tests_run++; \
	if ((act_v) !== (exp_v)) begin bad_count++; \
	$display("MISMATCH %s expected %h seen %h", what, exp_v, act_v); end end
module image_port_write_sequencer_bench;
	localparam logic [21:0] S = 22'h012310;
	logic        sys_clk, rstn, cyc, stb, we, ack;
	logic [9:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat, dat_o, r;
	wire logic   fs, ls, odd, wqn, mk, rdy, mwe;
	wire logic [7:0]  pix, mdat;
	wire logic [21:0] maddr;
	int          bad_count = 0;
	int          tests_run = 0;
	int          cyc_count = 0;
	logic [29:0] q[$];

	ipw_top dut (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.frame_sync_in(fs), .line_sync_in(ls), .odd_field_in(odd), .write_request_n(wqn),
		.pixel_byte_in(pix), .byte_mask_in(mk), .port_ready_out(rdy), .mem_we(mwe),
		.mem_addr(maddr), .mem_data(mdat));
	ipw_sender snd (.sys_clk(sys_clk), .port_ready_out(rdy), .frame_sync_in(fs),
		.line_sync_in(ls), .odd_field_in(odd), .write_request_n(wqn), .byte_mask_in(mk),
		.pixel_byte_in(pix));

	// ------------------------------------------------------------
	// Clock, monitor, timeout
	// ------------------------------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		if (mwe === 1'b1) q.push_back({maddr, mdat});
		cyc_count++;
		if (cyc_count == 6000)
		begin
			bad_count++;
			print_verdict();
		end
	end

	// ------------------------------------------------------------
	// Bus and byte tasks
	// ------------------------------------------------------------
	task wb(input logic w, input logic [7:0] i, input logic [7:0] d, input logic [3:0] s);
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		sel <= s;
		dat <= {24'h0, d};
		do @(posedge sys_clk); while (ack !== 1'b1);
		r = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task wr(input logic [7:0] i, input logic [7:0] d);
		wb(1'b1, i, d, 4'h1);
	endtask
	task rd(input logic [7:0] i, input logic [31:0] e);
		wb(1'b0, i, 8'h00, 4'h1);
		`CHK("register", e, r)
	endtask
	// Masked bytes must leave the write queue untouched
	task put(input logic [7:0] b, input logic m, input logic [21:0] a);
		int n;
		logic [29:0] w;
		n = q.size();
		snd.send(b, m);
		repeat (2) @(posedge sys_clk);
		`CHK("write count", n + int'(m), q.size())
		if (m && q.size() != 0)
		begin
			w = q.pop_front();
			`CHK("write word", {a, b}, w)
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task test_regs;
		rd(8'hf7, 32'h0);
		rd(8'he0, 32'h0);
		wr(8'he0, 8'h10);
		wr(8'he1, 8'h23);
		wr(8'he2, 8'h01);
		wr(8'he4, 8'h04);
		wr(8'he3, 8'hff);
		wr(8'hf3, 8'h01);
		wr(8'hf7, 8'h01);
		wb(1'b1, 8'he0, 8'hff, 4'h0);
		rd(8'he0, 32'h10);
		rd(8'he2, 32'h01);
		rd(8'he4, 32'h04);
		rd(8'he3, 32'h0);
		rd(8'h00, 32'h0);
		rd(8'hf3, 32'h01);
		$display("test_regs done");
	endtask
	task test_line;
		int i;
		snd.frame(1'b0);
		snd.line();
		`CHK("ready", 1'b1, rdy)
		put(8'ha1, 1'b1, S);
		put(8'hb2, 1'b0, S + 22'd1);
		put(8'hc3, 1'b1, S + 22'd2);
		put(8'hd4, 1'b1, S + 22'd3);
		repeat (4) @(posedge sys_clk);
		`CHK("ready", 1'b0, rdy)
		rd(8'hf0, 32'h06);
		rd(8'hf1, 32'h01);
		snd.line();
		put(8'he5, 1'b1, S + 22'd16);
		snd.line();
		for (i = 0; i < 4; i++) put(i[7:0], 1'b1, S + 22'd32 + i[21:0]);
		repeat (4) @(posedge sys_clk);
		`CHK("ready", 1'b0, rdy)
		$display("test_line done");
	endtask
	task test_ilace;
		wr(8'hf7, 8'h03);
		snd.frame(1'b1);
		snd.line();
		put(8'h11, 1'b1, S + 22'd16);
		snd.line();
		put(8'h22, 1'b1, S + 22'd48);
		snd.frame(1'b0);
		snd.line();
		put(8'h33, 1'b1, S);
		wr(8'hf7, 8'h00);
		repeat (4) @(posedge sys_clk);
		`CHK("ready", 1'b0, rdy)
		$display("test_ilace done");
	endtask

	task print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		rstn = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 10'h000;
		sel = 4'h0;
		dat = 32'h0;
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		test_regs();
		test_line();
		test_ilace();
		print_verdict();
	end
endmodule // image_port_write_sequencer_bench
`default_nettype wire
